// >>> mmsg_security_gate.sv
`timescale 1ns/1ps
// Overview of operation
// R1: After power-on reset in monitor mode, nothing proceeds until eight security bytes arrive.
// R2: When all eight bytes match the stored ones, flash reads and execution are allowed.
// R3: Once unlocked, access stays unlocked until the next power-on reset.
// R4: A reset other than power-on keeps the unlocked state and needs no new bytes.
// R5: On a mismatch the device stays in monitor mode but flash reads return an invalid value.
// R6: While locked, an instruction fetch from flash raises an illegal address reset.
// R7: The break character is sent only after the eighth security byte has arrived.
// R8: A RAM status byte has bit 6 set when the correct code was received.
// R9: After a failure the host must apply a power-on reset before trying again.
// R10: After a failure a RAM-run mass erase is still allowed and blanks all security bytes.
// R11: Users should program all eight security locations with non-blank values.
// R12: Bytes compare in ascending address order and match only if all eight agree.
module mmsg_security_gate
   import mmsg_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYCLES,
   parameter int BRK_BITS = BREAK_BITS
) (
   input wire logic core_clk, // 50 MHz clock
   input wire logic rst_n, // Any reset, active low, async
   input wire logic por_n, // Power-on reset, active low, async
   input wire logic monitor_mode, // Device entered monitor mode
   input wire logic monitor_serial_pin_i, // Serial pin level in
   output logic monitor_serial_pin_o, // Serial pin drive value
   output logic monitor_serial_pin_oe, // Serial pin output enable
   input wire mmsg_flash_req_t flash_req, // Core flash access
   input wire logic [7:0] flash_rdata, // Raw flash data
   output logic [7:0] core_rdata, // Gated read data
   output logic illegal_addr_rst, // Illegal address reset pulse
   input wire logic [63:0] stored_code, // Bytes at security window, lowest address low
   input wire logic mass_erase_req, // Mass erase request from RAM routine
   input wire logic exec_from_ram, // Erase routine runs from RAM
   output logic mass_erase_go, // Erase granted, one cycle after the request
   input wire logic [7:0] ram_addr, // RAM read address
   output logic [7:0] ram_status, // Status byte at that address
   output logic unlocked, // Flash access unlocked
   output logic cmd_ready // Ready for monitor commands
);
   mmsg_state_t state_q;
   logic unlock_q;
   logic sync1_q;
   logic sync2_q;
   logic [2:0] idx_q;
   logic ok_q;
   logic [15:0] bit_cnt_q;
   logic [7:0] brk_q;
   mmsg_byte_t rx_byte;
   logic f_ready;
   logic f_valid;
   logic [7:0] f_data;
   logic f_pop;
   logic last_byte;
   logic brk_done;

   //////////////////////////////////////////////////////////////////////
   // Pick stored byte by position within the window
   function automatic logic [7:0] code_byte(input logic [63:0] c, input logic [2:0] i);
      code_byte = c[{i, 3'b000} +: 8];
   endfunction : code_byte

   // Address falls inside flash window of the security bytes
   function automatic logic in_sec(input logic [15:0] a);
      in_sec = (a >= SEC_FIRST_ADDR) && (a <= SEC_LAST_ADDR);
   endfunction : in_sec

   //////////////////////////////////////////////////////////////////////
   // Pin synchroniser; first stage feeds only the second
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= monitor_serial_pin_i;
         sync2_q <= sync1_q;
      end
   end

   mmsg_uart_rx #(
      .BIT_CYC(BIT_CYC)
   ) u_rx (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rx_sync(sync2_q),
      .rx_byte(rx_byte)
   );

   // Bytes queue up so the compare can never drop one mid-stream
   mmsg_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(rx_byte.valid && state_q == ST_COLLECT),
      .in_ready(f_ready),
      .in_data(rx_byte.data),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   // Bytes leave the queue only while the code is being collected
   assign f_pop = f_valid && (state_q == ST_COLLECT);

   // The eighth byte of the code is taken in this cycle
   assign last_byte = f_pop && (idx_q == 3'(SEC_BYTES - 1));

   // Final break bit has run its full length
   assign brk_done = (bit_cnt_q == 16'h0000) && (brk_q == 8'h01);

   //////////////////////////////////////////////////////////////////////
   // Entry sequence; only power-on reset restarts it, so a warm reset
   // can never ask the host for a second code
   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         state_q <= ST_WAIT_POR;
      end else begin
         case (state_q)
            ST_WAIT_POR: begin
               if (monitor_mode) begin
                  state_q <= ST_COLLECT; // see R1
               end else begin
                  state_q <= ST_READY; // Normal start, flash stays locked
               end
            end
            ST_COLLECT: begin
               if (last_byte) begin
                  state_q <= ST_COMPARE; // see R1
               end
            end
            ST_COMPARE: begin
               state_q <= ST_BREAK; // see R7
            end
            ST_BREAK: begin
               if (brk_done) begin
                  state_q <= ST_READY;
               end
            end
            default: begin
               state_q <= ST_READY;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Position of the next expected byte, ascending; wraps after the eighth
   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         idx_q <= '0;
      end else if (f_pop) begin
         idx_q <= idx_q + 3'h1; // see R12
      end
   end

   // Match flag: one wrong byte spoils it, and nothing sets it again before
   // the next power-on reset, so a partly right code can never unlock
   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         ok_q <= 1'b1;
      end else if (f_pop && (f_data != code_byte(stored_code, idx_q))) begin
         ok_q <= 1'b0; // see R12
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Break timer: bit_cnt_q counts clocks within a bit, brk_q the bits left.
   // Loaded in the compare state, so the break cannot start before 8 bytes.
   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         bit_cnt_q <= '0;
         brk_q <= '0;
      end else if (state_q == ST_COMPARE) begin
         bit_cnt_q <= 16'(BIT_CYC - 1); // see R7
         brk_q <= 8'(BRK_BITS);
      end else if (state_q == ST_BREAK) begin
         if (bit_cnt_q != 16'h0000) begin
            bit_cnt_q <= bit_cnt_q - 16'h0001;
         end else if (brk_q != 8'h01) begin
            bit_cnt_q <= 16'(BIT_CYC - 1);
            brk_q <= brk_q - 8'h01;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Unlock latch: only power-on reset clears it, so other resets keep it
   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         unlock_q <= 1'b0; // see R3
      end else if (state_q == ST_COMPARE && ok_q) begin
         unlock_q <= 1'b1; // see R2, R4
      end
   end

   assign unlocked = unlock_q;

   //////////////////////////////////////////////////////////////////////
   // Break character: line held low for the break length, only after 8 bytes.
   // Registered so the pin cannot glitch while the state decodes.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         monitor_serial_pin_o <= 1'b1;
         monitor_serial_pin_oe <= 1'b0;
      end else begin
         monitor_serial_pin_o <= !(state_q == ST_BREAK); // see R7
         monitor_serial_pin_oe <= (state_q == ST_BREAK);
      end
   end

   // Command ready follows the entry sequence; a warm reset drops it until the first clock after release
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ready <= 1'b0;
      end else begin
         cmd_ready <= (state_q == ST_READY); // see R4
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Flash read gating: locked reads see a fixed filler, never the array
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_rdata <= '0;
      end else begin
         core_rdata <= unlock_q ? flash_rdata : LOCKED_READ_VALUE; // see R2, R5
      end
   end

   // Illegal fetch detection; every request targets flash, so any locked fetch
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         illegal_addr_rst <= 1'b0;
      end else begin
         illegal_addr_rst <= flash_req.req && flash_req.fetch && !unlock_q; // see R6
      end
   end

   //////////////////////////////////////////////////////////////////////
   // RAM status byte: only the unlock bit of one address is kept here
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ram_status <= '0;
      end else begin
         ram_status <= '0;
         if (ram_addr == STATUS_RAM_ADDR) begin
            ram_status[STATUS_UNLOCK_BIT] <= unlock_q; // see R8
         end
      end
   end

   // Mass erase from RAM stays allowed when locked; the array blanks the code
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mass_erase_go <= 1'b0;
      end else begin
         mass_erase_go <= mass_erase_req && exec_from_ram; // see R10
      end
   end
endmodule : mmsg_security_gate

// >>> mmsg_pkg.sv
package mmsg_pkg;
   // Security byte window in the flash array
   localparam logic [15:0] SEC_FIRST_ADDR = 16'hfff6;
   localparam logic [15:0] SEC_LAST_ADDR = 16'hfffd;
   localparam int SEC_BYTES = 8;
   localparam logic [7:0] BLANK_BYTE = 8'hff;
   // Value returned for flash reads while locked
   localparam logic [7:0] LOCKED_READ_VALUE = 8'had;
   // RAM status byte and unlock bit position
   localparam logic [7:0] STATUS_RAM_ADDR = 8'h80;
   localparam int STATUS_UNLOCK_BIT = 6;
   // Monitor line timing
   localparam int CLK_HZ = 50_000_000;
   localparam int BAUD = 9600;
   localparam int BIT_CYCLES = CLK_HZ / BAUD;
   localparam int BREAK_BITS = 10;
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } mmsg_byte_t;

   typedef struct packed {
      logic req;
      logic fetch;
      logic [15:0] addr;
   } mmsg_flash_req_t;

   typedef enum logic [2:0] {
      ST_WAIT_POR,
      ST_COLLECT,
      ST_COMPARE,
      ST_BREAK,
      ST_READY
   } mmsg_state_t;
endpackage : mmsg_pkg

// >>> mmsg_fifo.sv
`timescale 1ns/1ps
module mmsg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Async reset, active low
   input wire logic in_valid, // Write request
   output logic in_ready, // Space available
   input wire logic [WIDTH-1:0] in_data, // Write data
   output logic out_valid, // Data available
   input wire logic out_ready, // Read accept
   output logic [WIDTH-1:0] out_data // Head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   //////////////////////////////////////////////////////////////////////
   // Full and empty from pointer wrap bits
   assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_q[AW-1:0]];

   // Storage
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : mmsg_fifo

// >>> mmsg_uart_rx.sv
`timescale 1ns/1ps
module mmsg_uart_rx
   import mmsg_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYCLES
) (
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Async reset, active low
   input wire logic rx_sync, // Synchronised serial line
   output mmsg_byte_t rx_byte // Received byte, valid one cycle
);
   logic busy_q;
   logic [15:0] cnt_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;

   //////////////////////////////////////////////////////////////////////
   // 8N1 receiver sampling at mid-bit; a framing error drops the byte
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         cnt_q <= '0;
         bit_q <= '0;
         sh_q <= '0;
         rx_byte <= '0;
      end else begin
         rx_byte.valid <= 1'b0;
         if (!busy_q) begin
            if (!rx_sync) begin
               busy_q <= 1'b1;
               cnt_q <= 16'(BIT_CYC / 2);
               bit_q <= '0;
            end
         end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
         end else begin
            cnt_q <= 16'(BIT_CYC - 1);
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h0 && rx_sync) begin
               busy_q <= 1'b0; // False start bit
            end else if (bit_q >= 4'h1 && bit_q <= 4'h8) begin
               sh_q <= {rx_sync, sh_q[7:1]};
            end else if (bit_q == 4'h9) begin
               busy_q <= 1'b0;
               rx_byte.valid <= rx_sync;
               rx_byte.data <= sh_q;
            end
         end
      end
   end
endmodule : mmsg_uart_rx

// >>> mmsg_security_gate_properties.sv
`timescale 1ns/1ps
module mmsg_security_gate_properties
   import mmsg_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYCLES,
   parameter int BRK_BITS = BREAK_BITS
) (
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Any reset
   input wire logic por_n, // Power-on reset
   input wire logic monitor_serial_pin_o, // Pin drive
   input wire logic monitor_serial_pin_oe, // Pin enable
   input wire mmsg_flash_req_t flash_req, // Flash access
   input wire logic [7:0] flash_rdata, // Raw data
   input wire logic [7:0] core_rdata, // Gated data
   input wire logic illegal_addr_rst, // Illegal reset
   input wire logic mass_erase_req, // Erase request
   input wire logic exec_from_ram, // Running from RAM
   input wire logic mass_erase_go, // Erase grant
   input wire logic [7:0] ram_addr, // RAM address
   input wire logic [7:0] ram_status, // RAM status
   input wire logic unlocked, // Unlock state
   input wire logic cmd_ready // Ready for commands
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n || !por_n);
   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0] brk_cnt_q;
   // Count break cycles; 16 bits also holds the full-rate break length
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) brk_cnt_q <= 16'h0;
      else if (!monitor_serial_pin_oe) brk_cnt_q <= 16'h0;
      else brk_cnt_q <= brk_cnt_q + 16'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_rd_gate;
      flash_req.req |=> core_rdata == ($past(unlocked) ? $past(flash_rdata) : LOCKED_READ_VALUE);
   endproperty
   a_rd_gate: assert property (p_rd_gate) else $error("read gating wrong");
   property p_fetch;
      1 |=> illegal_addr_rst == $past(flash_req.req && flash_req.fetch && !unlocked);
   endproperty
   a_fetch: assert property (p_fetch) else $error("illegal reset wrong");
   property p_erase;
      1 |=> mass_erase_go == $past(mass_erase_req && exec_from_ram);
   endproperty
   a_erase: assert property (p_erase) else $error("erase grant wrong");
   property p_status;
      1 |=> ram_status[STATUS_UNLOCK_BIT] == ($past(ram_addr) == STATUS_RAM_ADDR && $past(unlocked));
   endproperty
   a_status: assert property (p_status) else $error("status bit wrong");
   property p_keep;
      disable iff (!por_n) unlocked |=> unlocked;
   endproperty
   a_keep: assert property (p_keep) else $error("unlock lost");
   property p_brk_lvl;
      monitor_serial_pin_oe |-> !monitor_serial_pin_o;
   endproperty
   a_brk_lvl: assert property (p_brk_lvl) else $error("break not low");
   property p_brk_len;
      $fell(monitor_serial_pin_oe) |-> brk_cnt_q == 16'(BRK_BITS * BIT_CYC);
   endproperty
   a_brk_len: assert property (p_brk_len) else $error("break length wrong");
   property p_brk_once;
      $rose(monitor_serial_pin_oe) |-> !cmd_ready;
   endproperty
   a_brk_once: assert property (p_brk_once) else $error("break while ready");
   property p_unl_brk;
      $rose(unlocked) |-> ##[1:4] $rose(monitor_serial_pin_oe);
   endproperty
   a_unl_brk: assert property (p_unl_brk) else $error("no break after unlock");
   c_unlock: cover property ($rose(unlocked));
   c_illegal: cover property (illegal_addr_rst);
   c_erase: cover property (mass_erase_go);
endmodule : mmsg_security_gate_properties

// >>> mmsg_host_model.sv
`timescale 1ns/1ps
module mmsg_host_model #(
   parameter int BIT_CYC = 4
) (
   input wire logic core_clk, // Clock
   output logic line // Host drive of the monitor pin
);
   // Pin is pulled up, so the released host line reads high
   initial line = 1'b1;
   // One 8N1 frame, low bit first; idles high after the stop bit
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge core_clk);
         line = frame[i];
         repeat (BIT_CYC - 1) @(negedge core_clk);
      end
   endtask : send_byte
endmodule : mmsg_host_model

// >>> test_mmsg_security_gate.sv
`timescale 1ns/1ps
module test_mmsg_security_gate;
   import mmsg_pkg::*;
   localparam logic [63:0] CODE = 64'h5a3c_9e17_c4d2_6b81; // Non-blank
   logic core_clk = 1'b0;
   logic rst_n = 1'b1, por_n = 1'b1, pin_o, pin_oe, host_line, line, ill, go, unlocked, rdy;
   logic erase_req = 1'b0, from_ram = 1'b0, mon_mode = 1'b1;
   mmsg_flash_req_t flash_req = '0;
   logic [7:0] flash_rdata = 8'h0, ram_addr = 8'h0, core_rdata, ram_status;
   logic [63:0] stored_code = CODE;
   int err_count = 0;
   int check_count = 0;
   // The pin reads the break drive when enabled, else the host
   assign line = pin_oe ? pin_o : host_line;
   always #10 core_clk = ~core_clk;
   mmsg_host_model #(.BIT_CYC(4)) mmsg_host_model_inst (.core_clk(core_clk), .line(host_line));
   mmsg_security_gate #(.BIT_CYC(4), .BRK_BITS(BREAK_BITS)) mmsg_security_gate_inst (
      .core_clk(core_clk), .rst_n(rst_n), .por_n(por_n), .monitor_mode(mon_mode),
      .monitor_serial_pin_i(line), .monitor_serial_pin_o(pin_o), .monitor_serial_pin_oe(pin_oe),
      .flash_req(flash_req), .flash_rdata(flash_rdata), .core_rdata(core_rdata),
      .illegal_addr_rst(ill), .stored_code(stored_code), .mass_erase_req(erase_req),
      .exec_from_ram(from_ram), .mass_erase_go(go), .ram_addr(ram_addr),
      .ram_status(ram_status), .unlocked(unlocked), .cmd_ready(rdy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      if (err_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   // Both resets low for three cycles; bytes may follow three cycles later
   task automatic power_on();
      por_n = 1'b0;
      rst_n = 1'b0;
      repeat (3) @(negedge core_clk);
      por_n = 1'b1;
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
   endtask : power_on
   // Sends eight bytes, then waits for break and ready under a bound
   task automatic send_code(input logic [63:0] code);
      logic brk;
      brk = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i == 7) chk({pin_oe, rdy}, 8'h0);
         mmsg_host_model_inst.send_byte(code[8*i +: 8]);
      end
      for (int n = 0; n < 300 && !rdy; n++) begin
         @(negedge core_clk);
         if (pin_oe && !pin_o) brk = 1'b1;
      end
      chk({brk, rdy}, 8'h3);
   endtask : send_code
   // One flash access with status address, sampled a cycle later
   task automatic access(input logic fetch, input logic [7:0] raddr);
      @(negedge core_clk); // Let an edge pass between two requests
      flash_req = '{req: 1'b1, fetch: fetch, addr: SEC_FIRST_ADDR};
      flash_rdata = 8'h3e;
      ram_addr = raddr;
      @(negedge core_clk);
      flash_req = '0;
   endtask : access
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_match();
      power_on();
      send_code(CODE);
      chk(unlocked, 1'b1);
      access(1'b1, STATUS_RAM_ADDR);
      chk({core_rdata, ram_status, 7'h0, ill}, {8'h3e, 8'h40, 8'h0});
      access(1'b0, 8'h81);
      chk(ram_status, 8'h0);
   endtask : t_match
   task automatic t_warm_reset();
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      access(1'b1, STATUS_RAM_ADDR);
      chk({unlocked, rdy, core_rdata, ill}, {1'b1, 1'b1, 8'h3e, 1'b0});
   endtask : t_warm_reset
   task automatic t_normal_boot();
      mon_mode = 1'b0;
      power_on();
      chk({unlocked, rdy, pin_oe}, {1'b0, 1'b1, 1'b0});
      access(1'b0, STATUS_RAM_ADDR);
      chk({core_rdata, ram_status}, {LOCKED_READ_VALUE, 8'h0});
      mon_mode = 1'b1;
   endtask : t_normal_boot
   task automatic t_mismatch();
      power_on();
      send_code(CODE ^ {8'h01, 56'h0});
      chk(unlocked, 1'b0);
      access(1'b0, STATUS_RAM_ADDR);
      chk({core_rdata, ram_status}, {LOCKED_READ_VALUE, 8'h0});
      access(1'b1, 8'h0);
      chk(ill, 1'b1);
      erase_req = 1'b1;
      from_ram = 1'b1;
      @(negedge core_clk);
      chk(go, 1'b1);
      from_ram = 1'b0;
      stored_code = {8{BLANK_BYTE}};
      @(negedge core_clk);
      chk(go, 1'b0);
      erase_req = 1'b0;
      power_on();
      send_code({8{BLANK_BYTE}});
      chk(unlocked, 1'b1);
   endtask : t_mismatch
   initial begin
      t_match();
      t_warm_reset();
      t_mismatch();
      t_normal_boot();
      report_and_stop();
   end
   // Three codes of about 400 cycles each fit well inside this span
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      report_and_stop();
   end
endmodule : test_mmsg_security_gate
bind mmsg_security_gate mmsg_security_gate_properties #(.BIT_CYC(BIT_CYC), .BRK_BITS(BRK_BITS))
   mmsg_security_gate_properties_inst (.core_clk(core_clk), .rst_n(rst_n), .por_n(por_n),
   .monitor_serial_pin_o(monitor_serial_pin_o), .monitor_serial_pin_oe(monitor_serial_pin_oe),
   .flash_req(flash_req), .flash_rdata(flash_rdata), .core_rdata(core_rdata),
   .illegal_addr_rst(illegal_addr_rst), .mass_erase_req(mass_erase_req),
   .exec_from_ram(exec_from_ram), .mass_erase_go(mass_erase_go), .ram_addr(ram_addr),
   .ram_status(ram_status), .unlocked(unlocked), .cmd_ready(cmd_ready));
